// ==== bench/trig_partner.sv ====
// far-side controller: trigger driver and pulled-up status lines
// assumes tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module trig_partner (
   input wire logic clk,
   input wire logic oe_one,
   input wire logic oe_two,
   output logic trig,
   output logic pin_one,
   output logic pin_two
);
   // ****************************************
   // trigger and pins
   // ****************************************
   initial trig = 1'b0;
   // released line floats to the pull-up level
   assign pin_one = ~oe_one;
   assign pin_two = ~oe_two;
   task pulse(input int hi, input int lo);
      trig <= 1'b1;
      repeat (hi) @(posedge clk);
      trig <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask : pulse
   task level(input logic v);
      trig <= v;
      repeat (12) @(posedge clk);
   endtask : level
endmodule : trig_partner

// ==== bench/trig_sig_props.sv ====
// checker of the trigger and status block, top ports only
// assumes trigger pulses longer than the filter span
`timescale 1ns/1ps
module trig_sig_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic TRIGGER_IN,
   input wire logic FRONT_PANEL_LOCKOUT,
   input wire logic STEP_EXEC,
   input wire logic SEQ_START,
   input wire logic SEQ_JUMP_STOP,
   input wire logic MINMAX_CAPTURE,
   input wire logic MINMAX_RELOAD,
   input wire logic STATUS_OUTPUT_ONE_O,
   input wire logic STATUS_OUTPUT_TWO_O
);
   // ****************************************
   // properties
   // ****************************************
   // past depth 3 sits inside the filter span
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   AST_PINS_LOW: assert property (!STATUS_OUTPUT_ONE_O && !STATUS_OUTPUT_TWO_O)
      else $error("status pin data not low");
   AST_EXEC_AFTER_LOW: assert property (STEP_EXEC |-> !$past(TRIGGER_IN, 3) && !$past(TRIGGER_IN, 4))
      else $error("step without fall");
   AST_EXEC_ONE_CYCLE: assert property (STEP_EXEC |=> !STEP_EXEC)
      else $error("step pulse too long");
   AST_START_AFTER_RISE: assert property (SEQ_START |-> $past(TRIGGER_IN, 3) ##1 !SEQ_START)
      else $error("start without rise");
   AST_JUMP_AFTER_FALL: assert property (SEQ_JUMP_STOP |-> !$past(TRIGGER_IN, 3))
      else $error("jump without fall");
   AST_LOCK_AFTER_HIGH: assert property ($rose(FRONT_PANEL_LOCKOUT) |-> $past(TRIGGER_IN, 3))
      else $error("lockout with trigger low");
   AST_CAPTURE_STOP: assert property ($fell(MINMAX_CAPTURE) |-> $past(TRIGGER_IN, 3))
      else $error("capture stopped with trigger low");
   AST_RELOAD_RESTART: assert property (MINMAX_RELOAD |-> !$past(TRIGGER_IN, 3) ##[0:1] MINMAX_CAPTURE)
      else $error("bad reload");
endmodule : trig_sig_props

bind trigger_status_top trig_sig_props trig_sig_props_i (.CLK(CLK), .RST_N(RST_N),
   .TRIGGER_IN(TRIGGER_IN), .FRONT_PANEL_LOCKOUT(FRONT_PANEL_LOCKOUT), .STEP_EXEC(STEP_EXEC),
   .SEQ_START(SEQ_START), .SEQ_JUMP_STOP(SEQ_JUMP_STOP), .MINMAX_CAPTURE(MINMAX_CAPTURE),
   .MINMAX_RELOAD(MINMAX_RELOAD), .STATUS_OUTPUT_ONE_O(STATUS_OUTPUT_ONE_O),
   .STATUS_OUTPUT_TWO_O(STATUS_OUTPUT_TWO_O));

// ==== bench/trigger_status_top_bench.sv ====
// self-checking bench of the trigger and status block
// assumes filter 4 and long-high 40 cycles
`timescale 1ns/1ps
module trigger_status_top_bench;
   import trig_sig_pkg::*;
   logic clk, rst_n, hsel, hwrite, hrdy, hresp, trig, ot, ov, on_r, off_r, cc, ovl, sr, sf;
   logic pw_o, lock, ex, st, jp, cap, rl, o1, e1, o2, e2, p1, p2;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [7:0] sa;
   logic [15:0] mv, mc, rv, rc, rh;
   logic [7:0] exq[$];
   int num_errors, n_compared, n_ev, e0, m, sel, pw;
   // ****************************************
   // design, far side, monitors
   // ****************************************
   trigger_status_top #(.FILTER_CYCLES(4), .LONG_CYCLES(40)) trigger_status_top_i (
      .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp),
      .HRDATA(hrdata), .TRIGGER_IN(trig), .OVERTEMP_TRIP(ot), .OVERVOLTAGE_TRIP(ov),
      .MANUAL_ON_REQ(on_r), .MANUAL_OFF_REQ(off_r), .CC_MODE(cc), .POWER_OVERLOAD(ovl),
      .SEQ_RUNNING(sr), .STEP_FLAG(sf), .MEAS_VOLT(mv), .MEAS_CURR(mc), .REF_VOLT_254(rv),
      .REF_CURR_254(rc), .REF_CURR_255(rh), .POWER_OUTPUT_ON(pw_o), .FRONT_PANEL_LOCKOUT(lock),
      .STEP_ADDR(sa), .STEP_EXEC(ex), .SEQ_START(st), .SEQ_JUMP_STOP(jp), .MINMAX_CAPTURE(cap),
      .MINMAX_RELOAD(rl), .STATUS_OUTPUT_ONE_I(p1), .STATUS_OUTPUT_ONE_O(o1),
      .STATUS_OUTPUT_ONE_OE(e1), .STATUS_OUTPUT_TWO_I(p2), .STATUS_OUTPUT_TWO_O(o2),
      .STATUS_OUTPUT_TWO_OE(e2));
   trig_partner trig_partner_i (.clk(clk), .oe_one(e1), .oe_two(e2), .trig(trig),
      .pin_one(p1), .pin_two(p2));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ex === 1'b1) exq.push_back(sa);
      n_ev += ex + st + jp + rl;
   end
   // ****************************************
   // tasks and model
   // ****************************************
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      q = hrdata;
      chk(0, hresp);
   endtask : bus
   task chk(input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %0t %h %h", $time, e, g);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   function logic exp_oe(input int s);
      case (s)
         1: return 1'b1;
         2: return pw == 0;
         3: return pw != 0 && (cc || ovl);
         4: return sr;
         5: return sr && sf;
         6: return mv < rv;
         7: return mc < rc;
         8: return mc > rh;
         default: return 1'b0;
      endcase
   endfunction : exp_oe
   task tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // ****************************************
   // tests
   // ****************************************
   initial begin
      tick(20000);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'he8cd694c));
      rst_n = 0; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0; ot = 0; ov = 0;
      on_r = 0; off_r = 0; cc = 0; ovl = 0; sr = 0; sf = 0; mv = 0; mc = 0; rv = 0; rc = 0;
      rh = 0; pw = 1;
      tick(12);
      rst_n <= 1'b1;
      bus(1, 8'h08, 32'h0503);
      bus(1, 8'h00, 32'h2);
      for (int i = 0; i < 4; i++) trig_partner_i.pulse(10, 12);
      trig_partner_i.pulse(60, 12);
      trig_partner_i.pulse(10, 12);
      for (int i = 0; i < 5; i++) chk(i > 2 ? 3 : 3 + i, exq[i]);
      chk(5, exq.size());
      $display("test recall done");
      bus(1, 8'h00, 32'h1);
      bus(1, 8'h0c, 32'h1);
      tick(3);
      chk(1, pw_o);
      trig_partner_i.level(1);
      chk(0, pw_o);
      bus(1, 8'h0c, 32'h1);
      on_r <= 1'b1;
      tick(1);
      on_r <= 1'b0;
      tick(3);
      chk(0, pw_o);
      m = $urandom % 2;
      ot <= (m == 0);
      ov <= (m == 1);
      trig_partner_i.level(0);
      chk(0, pw_o);
      ot <= 1'b0;
      ov <= 1'b0;
      trig_partner_i.level(1);
      trig_partner_i.level(0);
      chk(1, pw_o);
      $display("test gate done");
      bus(1, 8'h00, 32'h0);
      e0 = n_ev;
      trig_partner_i.pulse(10, 12);
      chk(e0, n_ev);
      chk(1, pw_o);
      bus(1, 8'h00, 32'h103);
      e0 = n_ev;
      trig_partner_i.level(1);
      chk(e0 + 1, n_ev);
      trig_partner_i.level(0);
      chk(e0 + 2, n_ev);
      bus(1, 8'h00, 32'h4);
      trig_partner_i.level(1);
      chk(1, lock);
      trig_partner_i.level(0);
      chk(0, lock);
      bus(1, 8'h00, 32'h205);
      tick(2);
      chk(1, cap);
      trig_partner_i.level(1);
      chk(0, cap);
      e0 = n_ev;
      trig_partner_i.level(0);
      chk(e0 + 1, n_ev);
      chk(1, cap);
      $display("test modes done");
      for (int i = 0; i < 18; i++) begin
         sel = i % 9;
         if (i == 9) begin
            off_r <= 1'b1;
            tick(1);
            off_r <= 1'b0;
            pw = 0;
         end
         cc <= 1'($urandom); ovl <= 1'($urandom); sr <= 1'($urandom); sf <= 1'($urandom);
         mv <= 16'($urandom % 4); mc <= 16'($urandom % 4); rv <= 16'($urandom % 4);
         rc <= 16'($urandom % 4); rh <= 16'($urandom % 4);
         bus(1, 8'h04, {24'h0, 4'((sel + 4) % 9), 4'(sel)});
         tick(2);
         chk(exp_oe(sel), e1);
         chk(exp_oe((sel + 4) % 9), e2);
      end
      $display("test status done");
      bus(1, 8'h0c, 32'h4);
      bus(0, 8'h14, 32'h0);
      chk(32'h02380503, q);
      bus(1, 8'h00, 32'h304);
      bus(0, 8'h14, 32'h0);
      chk(32'h02380503, q);
      bus(0, 8'h00, 32'h0);
      chk(32'h304, q);
      bus(0, 8'h20, 32'h0);
      chk(32'h0, q);
      $display("test regs done");
      tally_and_finish();
   end
endmodule : trigger_status_top_bench

// ==== core/status_output_select.sv ====
// one open-collector status output and its condition selector
// assumes measured values and references share one unsigned scale
`timescale 1ns/1ps
module status_output_select
   import trig_sig_pkg::*;
#(
   parameter int MEAS_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire sig_sel_t sel,
   input wire logic output_on,
   input wire logic cc_mode,
   input wire logic overload,
   input wire logic seq_running,
   input wire logic step_flag,
   input wire logic [MEAS_W-1:0] meas_volt,
   input wire logic [MEAS_W-1:0] meas_curr,
   input wire logic [MEAS_W-1:0] ref_volt_lo,
   input wire logic [MEAS_W-1:0] ref_curr_lo,
   input wire logic [MEAS_W-1:0] ref_curr_hi,
   output logic pin_o,
   output logic pin_oe
);

   generate
      if (MEAS_W < 1) begin : g_bad
         $error("measurement width must be positive");
      end
   endgenerate

   // active low on the pin means the transistor pulls: oe high
   logic act_r, act_nxt;

   always_comb begin
      case (sel)
         SIG_OFF: act_nxt = 1'b0; // R17
         SIG_ON: act_nxt = 1'b1; // R17
         SIG_POWER: act_nxt = ~output_on; // R18
         SIG_REGULATION: act_nxt = output_on & (cc_mode | overload); // R19
         SIG_SEQ_RUN: act_nxt = seq_running; // R20
         SIG_STEP_FLAG: act_nxt = seq_running & step_flag; // R21 R22
         SIG_VOLT_BELOW: act_nxt = meas_volt < ref_volt_lo; // R23
         SIG_CURR_BELOW: act_nxt = meas_curr < ref_curr_lo; // R24
         SIG_CURR_ABOVE: act_nxt = meas_curr > ref_curr_hi; // R25
         default: act_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_r <= 1'b0;
      end else begin
         act_r <= act_nxt;
      end
   end

   assign pin_o = 1'b0;
   assign pin_oe = act_r;

endmodule : status_output_select

// ==== core/trig_sig_map.svh ====
// constant map of the trigger and status signal block
// assumes a 50 MHz clock and word-aligned 32-bit registers
`ifndef TRIG_SIG_MAP_SVH
`define TRIG_SIG_MAP_SVH

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 50
`define TRIG_FILTER_US 1000
`define LONG_HIGH_MS 1000

// ****************************************
// register offsets
// ****************************************
`define ADDR_BITS 8
`define REG_CTRL 8'h00
`define REG_SIGSEL 8'h04
`define REG_SEQADDR 8'h08
`define REG_CMD 8'h0c
`define REG_STATUS 8'h10
`define REG_SETUP 8'h14

// ****************************************
// fields and reset values
// ****************************************
`define CTRL_MODE_LSB 0
`define CTRL_SEQEN_BIT 8
`define CTRL_MMEN_BIT 9
`define SIGSEL_ONE_LSB 0
`define SIGSEL_TWO_LSB 4
`define SEQ_START_LSB 0
`define SEQ_STOP_LSB 8
`define CMD_ON_BIT 0
`define CMD_OFF_BIT 1
`define CMD_SAVE_BIT 2
`define SIGSEL_RST 8'h00
`define SEQADDR_RST 16'h0000
`define STEP_ADDR_RST 8'h00

`endif

// ==== core/trig_sig_pkg.sv ====
// types shared by the trigger and status signal block
// assumes trig_sig_map.svh supplies the numeric constants
package trig_sig_pkg;

   // ****************************************
   // trigger function selection
   // ****************************************
   typedef enum logic [2:0] {
      TRIG_OFF = 3'h0,
      TRIG_OUT_GATE = 3'h1,
      TRIG_RECALL = 3'h2,
      TRIG_SEQUENCE = 3'h3,
      TRIG_LOCKOUT = 3'h4,
      TRIG_MINMAX = 3'h5
   } trig_mode_t;

   // ****************************************
   // status output selection
   // ****************************************
   typedef enum logic [3:0] {
      SIG_OFF = 4'h0,
      SIG_ON = 4'h1,
      SIG_POWER = 4'h2,
      SIG_REGULATION = 4'h3,
      SIG_SEQ_RUN = 4'h4,
      SIG_STEP_FLAG = 4'h5,
      SIG_VOLT_BELOW = 4'h6,
      SIG_CURR_BELOW = 4'h7,
      SIG_CURR_ABOVE = 4'h8
   } sig_sel_t;

   // ****************************************
   // stepwise recall pulse tracker, gray except the RC_LONG to RC_WAIT return
   // ****************************************
   typedef enum logic [1:0] {
      RC_WAIT = 2'b00,
      RC_PULSE = 2'b01,
      RC_LONG = 2'b11
   } recall_state_t;

endpackage : trig_sig_pkg

// ==== core/trigger_input_filter.sv ====
// trigger input conditioning: two-stage synchroniser, level filter, edge detect
// assumes the raw trigger may change at any time relative to CLK
`timescale 1ns/1ps
`include "trig_sig_map.svh"
module trigger_input_filter
   import trig_sig_pkg::*;
#(
   parameter int FILTER_CYCLES = `TRIG_FILTER_US * `CLK_MHZ
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic raw,
   output logic level,
   output logic rise,
   output logic fall
);

   generate
      if (FILTER_CYCLES < 1) begin : g_bad
         $error("filter length must be at least one cycle");
      end
   endgenerate

   logic sync1_r, sync2_r, level_r, level_d_r;
   logic [31:0] cnt_r, cnt_nxt;
   logic level_nxt;

   // ****************************************
   // filter: a level counts once stable, so glitches do not act
   // ****************************************
   always_comb begin
      level_nxt = level_r;
      cnt_nxt = 32'h0;
      if (sync2_r != level_r) begin
         if (cnt_r >= 32'(FILTER_CYCLES - 1)) begin
            level_nxt = sync2_r; // R1
         end else begin
            cnt_nxt = cnt_r + 32'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         level_r <= 1'b0;
         level_d_r <= 1'b0;
         cnt_r <= 32'h0;
      end else begin
         sync1_r <= raw; // R2
         sync2_r <= sync1_r;
         level_r <= level_nxt;
         level_d_r <= level_r;
         cnt_r <= cnt_nxt;
      end
   end

   assign level = level_r;
   assign rise = level_r & ~level_d_r; // R2
   assign fall = ~level_r & level_d_r; // R2

endmodule : trigger_input_filter

// ==== core/trigger_status_top.sv ====
// trigger input and status output logic of the remote connector
// assumes an AHB-Lite master, one 50 MHz clock, and an external sequencer,
// min/max store and regulator
//
// Summary of operation
// R1: trigger is a filtered binary level, acted on within 1 to 15 ms.
// R2: trigger synchronised; edges from consecutive samples.
// R3: mode off ignores every trigger level and edge.
// R4: gating mode: rising edge switches the power output off.
// R5: gating mode: trigger high holds output off, refusing on requests.
// R6: gating mode: falling edge switches output on unless a trip is active.
// R7: recall mode: far side gives high pulses of 11 to 800 ms.
// R8: recall mode: high over one second resets step address to start.
// R9: recall mode: short pulse falling edge executes the next step.
// R10: steps run start to stop, then wrap back to start.
// R11: sequence mode with sequencing enabled: rising edge starts from start.
// R12: sequence mode: falling edge jumps straight to the stop address.
// R13: lockout mode: trigger high disables front panel, local key included.
// R14: min/max mode: capture runs while low, frozen while high.
// R15: min/max mode: falling edge reloads extremes, then capture restarts.
// R16: trigger mode is left out of the saved setup image.
// R17: status output off is always passive high, on always active low.
// R18: power selection: passive with output on, active with output off.
// R19: regulation selection: active in constant current or overload; here only while the power output is on.
// R20: sequence selection: active while a sequence runs.
// R21: step selection: active while a flagged step executes.
// R22: step flag lasts exactly the step's dwell time.
// R23: voltage below reference 254 drives the output active.
// R24: current below reference 254 drives the output active.
// R25: current above reference 255 drives the output active.
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "trig_sig_map.svh"
module trigger_status_top
   import trig_sig_pkg::*;
#(
   parameter int MEAS_W = 16,
   parameter int FILTER_CYCLES = `TRIG_FILTER_US * `CLK_MHZ,
   parameter int LONG_CYCLES = `LONG_HIGH_MS * 1000 * `CLK_MHZ
) (
   input wire logic CLK,
   input wire logic RST_N,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // trigger and device state
   input wire logic TRIGGER_IN,
   input wire logic OVERTEMP_TRIP,
   input wire logic OVERVOLTAGE_TRIP,
   input wire logic MANUAL_ON_REQ,
   input wire logic MANUAL_OFF_REQ,
   input wire logic CC_MODE,
   input wire logic POWER_OVERLOAD,
   input wire logic SEQ_RUNNING,
   input wire logic STEP_FLAG,
   input wire logic [MEAS_W-1:0] MEAS_VOLT,
   input wire logic [MEAS_W-1:0] MEAS_CURR,
   input wire logic [MEAS_W-1:0] REF_VOLT_254,
   input wire logic [MEAS_W-1:0] REF_CURR_254,
   input wire logic [MEAS_W-1:0] REF_CURR_255,
   // controls to the rest of the supply
   output logic POWER_OUTPUT_ON,
   output logic FRONT_PANEL_LOCKOUT,
   output logic [7:0] STEP_ADDR,
   output logic STEP_EXEC,
   output logic SEQ_START,
   output logic SEQ_JUMP_STOP,
   output logic MINMAX_CAPTURE,
   output logic MINMAX_RELOAD,
   // open-collector status outputs
   input wire logic STATUS_OUTPUT_ONE_I,
   output logic STATUS_OUTPUT_ONE_O,
   output logic STATUS_OUTPUT_ONE_OE,
   input wire logic STATUS_OUTPUT_TWO_I,
   output logic STATUS_OUTPUT_TWO_O,
   output logic STATUS_OUTPUT_TWO_OE
);

   generate
      if (LONG_CYCLES <= FILTER_CYCLES || MEAS_W < 1) begin : g_bad
         $error("long-pulse time must exceed the filter time");
      end
   endgenerate

   // ****************************************
   // trigger conditioning
   // ****************************************
   logic trig_level, trig_rise, trig_fall;

   trigger_input_filter #(
      .FILTER_CYCLES(FILTER_CYCLES)
   ) u_filter (
      .clk(CLK),
      .rst_n(RST_N),
      .raw(TRIGGER_IN),
      .level(trig_level),
      .rise(trig_rise),
      .fall(trig_fall)
   );

   // ****************************************
   // ahb-lite register slave
   // ****************************************
   logic [2:0] mode_r, mode_nxt;
   logic seq_en_r, seq_en_nxt;
   logic mm_en_r, mm_en_nxt;
   logic [7:0] sigsel_r, sigsel_nxt;
   logic [15:0] seqaddr_r, seqaddr_nxt;
   logic [25:0] setup_r, setup_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [`ADDR_BITS-1:0] wr_addr_r, wr_addr_nxt;
   logic cmd_on, cmd_off, cmd_save;
   logic addr_phase;
   logic [31:0] status_word;
   trig_mode_t mode;
   logic [7:0] start_addr, stop_addr;

   assign mode = trig_mode_t'(mode_r);
   assign start_addr = seqaddr_r[`SEQ_START_LSB +: 8];
   assign stop_addr = seqaddr_r[`SEQ_STOP_LSB +: 8];
   assign addr_phase = HSEL & HTRANS[1] & HREADY;
   assign cmd_on = wr_pend_r & (wr_addr_r == `REG_CMD) & HWDATA[`CMD_ON_BIT];
   assign cmd_off = wr_pend_r & (wr_addr_r == `REG_CMD) & HWDATA[`CMD_OFF_BIT];
   assign cmd_save = wr_pend_r & (wr_addr_r == `REG_CMD) & HWDATA[`CMD_SAVE_BIT];

   always_comb begin
      mode_nxt = mode_r;
      seq_en_nxt = seq_en_r;
      mm_en_nxt = mm_en_r;
      sigsel_nxt = sigsel_r;
      seqaddr_nxt = seqaddr_r;
      setup_nxt = setup_r;
      rdata_nxt = rdata_r;
      wr_pend_nxt = addr_phase & HWRITE;
      wr_addr_nxt = HADDR[`ADDR_BITS-1:0];
      if (wr_pend_r) begin
         case (wr_addr_r)
            `REG_CTRL: begin
               mode_nxt = HWDATA[`CTRL_MODE_LSB +: 3];
               seq_en_nxt = HWDATA[`CTRL_SEQEN_BIT];
               mm_en_nxt = HWDATA[`CTRL_MMEN_BIT];
            end
            `REG_SIGSEL: sigsel_nxt = HWDATA[7:0];
            `REG_SEQADDR: seqaddr_nxt = HWDATA[15:0];
            default: begin
            end
         endcase
      end
      // mode left out of setup image
      if (cmd_save) begin
         setup_nxt = {mm_en_r, seq_en_r, sigsel_r, seqaddr_r}; // R16
      end
      if (addr_phase && !HWRITE) begin
         case (HADDR[`ADDR_BITS-1:0])
            `REG_CTRL: rdata_nxt = {22'h0, mm_en_r, seq_en_r, 5'h0, mode_r};
            `REG_SIGSEL: rdata_nxt = {24'h0, sigsel_r};
            `REG_SEQADDR: rdata_nxt = {16'h0, seqaddr_r};
            `REG_STATUS: rdata_nxt = status_word;
            `REG_SETUP: rdata_nxt = {6'h0, setup_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_r <= TRIG_OFF;
         seq_en_r <= 1'b0;
         mm_en_r <= 1'b0;
         sigsel_r <= `SIGSEL_RST;
         seqaddr_r <= `SEQADDR_RST;
         setup_r <= 26'h0;
         rdata_r <= 32'h0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         mode_r <= mode_nxt;
         seq_en_r <= seq_en_nxt;
         mm_en_r <= mm_en_nxt;
         sigsel_r <= sigsel_nxt;
         seqaddr_r <= seqaddr_nxt;
         setup_r <= setup_nxt;
         rdata_r <= rdata_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
      end
   end

   // no wait states, always okay
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = rdata_r;

   // ****************************************
   // power output gating
   // ****************************************
   logic out_on_r, out_on_nxt;
   logic on_req, off_req, gate_mode;

   assign gate_mode = (mode == TRIG_OUT_GATE);
   assign on_req = MANUAL_ON_REQ | cmd_on;
   assign off_req = MANUAL_OFF_REQ | cmd_off;

   always_comb begin
      out_on_nxt = out_on_r;
      if (off_req) begin
         out_on_nxt = 1'b0;
      end else if (on_req && !(gate_mode && trig_level)) begin
         out_on_nxt = 1'b1; // R5 R6
      end
      if (gate_mode && trig_rise) begin
         out_on_nxt = 1'b0; // R4
      end else if (gate_mode && trig_level) begin
         out_on_nxt = 1'b0; // R5
      end else if (gate_mode && trig_fall && !OVERTEMP_TRIP && !OVERVOLTAGE_TRIP) begin
         out_on_nxt = 1'b1; // R6
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_on_r <= 1'b0;
      end else begin
         out_on_r <= out_on_nxt;
      end
   end

   // ****************************************
   // stepwise recall
   // ****************************************
   // 11 to 800 ms pulse bounds are the controller's
   recall_state_t rc_r, rc_nxt;
   logic [31:0] high_cnt_r, high_cnt_nxt;
   logic [7:0] next_addr_r, next_addr_nxt, exec_addr_r, exec_addr_nxt;
   logic exec_r, exec_nxt;
   logic recall_mode;

   assign recall_mode = (mode == TRIG_RECALL);

   always_comb begin
      rc_nxt = rc_r;
      high_cnt_nxt = 32'h0;
      next_addr_nxt = next_addr_r;
      exec_addr_nxt = exec_addr_r;
      exec_nxt = 1'b0;
      if (!recall_mode) begin
         rc_nxt = RC_WAIT; // R3
         next_addr_nxt = start_addr;
      end else begin
         case (rc_r)
            RC_WAIT: begin
               if (trig_rise) begin
                  rc_nxt = RC_PULSE; // R7
               end
            end
            RC_PULSE: begin
               high_cnt_nxt = high_cnt_r + 32'h1;
               if (trig_fall) begin
                  rc_nxt = RC_WAIT;
                  exec_nxt = 1'b1; // R9
                  exec_addr_nxt = next_addr_r; // R10
                  next_addr_nxt = (next_addr_r == stop_addr) ? start_addr
                                  : next_addr_r + 8'h1; // R10
               end else if (high_cnt_r >= 32'(LONG_CYCLES)) begin
                  rc_nxt = RC_LONG;
                  next_addr_nxt = start_addr; // R8
               end
            end
            RC_LONG: begin
               // execution waits for the next pulse
               if (trig_fall) begin
                  rc_nxt = RC_WAIT; // R8
               end
            end
            default: rc_nxt = RC_WAIT;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rc_r <= RC_WAIT;
         high_cnt_r <= 32'h0;
         next_addr_r <= `STEP_ADDR_RST;
         exec_addr_r <= `STEP_ADDR_RST;
         exec_r <= 1'b0;
      end else begin
         rc_r <= rc_nxt;
         high_cnt_r <= high_cnt_nxt;
         next_addr_r <= next_addr_nxt;
         exec_addr_r <= exec_addr_nxt;
         exec_r <= exec_nxt;
      end
   end

   // ****************************************
   // sequence, lockout and min/max control
   // ****************************************
   logic seq_start_r, seq_start_nxt, seq_stop_r, seq_stop_nxt;
   logic lock_r, lock_nxt, cap_r, cap_nxt, reload_r, reload_nxt;

   always_comb begin
      seq_start_nxt = (mode == TRIG_SEQUENCE) & seq_en_r & trig_rise; // R11
      seq_stop_nxt = (mode == TRIG_SEQUENCE) & trig_fall; // R12
      lock_nxt = (mode == TRIG_LOCKOUT) & trig_level; // R13
      reload_nxt = (mode == TRIG_MINMAX) & trig_fall; // R15
      if (mode == TRIG_MINMAX) begin
         cap_nxt = ~trig_level; // R14
      end else begin
         cap_nxt = mm_en_r;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         seq_start_r <= 1'b0;
         seq_stop_r <= 1'b0;
         lock_r <= 1'b0;
         cap_r <= 1'b0;
         reload_r <= 1'b0;
      end else begin
         seq_start_r <= seq_start_nxt;
         seq_stop_r <= seq_stop_nxt;
         lock_r <= lock_nxt;
         cap_r <= cap_nxt;
         reload_r <= reload_nxt;
      end
   end

   assign POWER_OUTPUT_ON = out_on_r;
   assign FRONT_PANEL_LOCKOUT = lock_r;
   assign STEP_ADDR = exec_addr_r;
   assign STEP_EXEC = exec_r;
   assign SEQ_START = seq_start_r;
   assign SEQ_JUMP_STOP = seq_stop_r;
   assign MINMAX_CAPTURE = cap_r;
   assign MINMAX_RELOAD = reload_r;

   // ****************************************
   // status outputs
   // ****************************************
   logic [1:0] sig_o, sig_oe;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sig
         status_output_select #(
            .MEAS_W(MEAS_W)
         ) u_sel (
            .clk(CLK),
            .rst_n(RST_N),
            .sel(sig_sel_t'(sigsel_r[gi*4 +: 4])),
            .output_on(out_on_r),
            .cc_mode(CC_MODE),
            .overload(POWER_OVERLOAD),
            .seq_running(SEQ_RUNNING),
            .step_flag(STEP_FLAG),
            .meas_volt(MEAS_VOLT),
            .meas_curr(MEAS_CURR),
            .ref_volt_lo(REF_VOLT_254),
            .ref_curr_lo(REF_CURR_254),
            .ref_curr_hi(REF_CURR_255),
            .pin_o(sig_o[gi]),
            .pin_oe(sig_oe[gi])
         );
      end
   endgenerate

   assign STATUS_OUTPUT_ONE_O = sig_o[0];
   assign STATUS_OUTPUT_ONE_OE = sig_oe[0];
   assign STATUS_OUTPUT_TWO_O = sig_o[1];
   assign STATUS_OUTPUT_TWO_OE = sig_oe[1];

   // pin readback shows a shorted line
   assign status_word = {7'h0, exec_addr_r, next_addr_r, STATUS_OUTPUT_TWO_I,
                         STATUS_OUTPUT_ONE_I, rc_r, reload_r, cap_r, lock_r,
                         trig_level, out_on_r};

endmodule : trigger_status_top
